// ---- verilog/vlsd_pkg.sv ----
// vlsd_pkg: register offsets, field positions, states and carrier structs
// for the vl slave cycle decoder; assumes an 8-bit register index space.
package vlsd_pkg;
  localparam logic [7:0] REG_SHADOW_A = 8'h30;
  localparam logic [7:0] REG_SHADOW_B = 8'h31;
  localparam logic [7:0] REG_SHADOW_C = 8'h32;
  localparam logic [7:0] REG_RELOC = 8'h33;
  localparam logic [7:0] REG_SMM = 8'h5B;
  localparam logic [7:0] REG_DRAM_SIZE = 8'h81;
  localparam logic [7:0] REG_BUS_TIMING = 8'h83;
  localparam logic [7:0] REG_FAST_ISA = 8'h92;
  localparam logic [7:0] REG_WIN_START = 8'h87;
  localparam logic [7:0] REG_WIN_STEP = 8'h03;
  localparam int NUM_WIN = 3;
  localparam int SHC_HI_MEM_BIT = 2;
  localparam int RELOC_256_BIT = 2;
  localparam int RELOC_384_BIT = 3;
  localparam int SMM_ON_BIT = 3;
  localparam int SMM_AB_BIT = 4;
  localparam int BT_TRDY_SYNC_BIT = 5;
  localparam int BT_LATE_SAMPLE_BIT = 6;
  localparam int WA_PCI_EN_BIT = 7;
  localparam int WA_WBUF_EN_BIT = 6;
  localparam int WA_SIZE_LSB = 2;
  localparam int FI_SIZE64_BIT = 7;
  localparam logic [31:0] SHADOW_BASE = 32'h000C_0000;
  localparam logic [31:0] SMM_BASE = 32'h000A_0000;
  localparam logic [31:0] SMM_TOP = 32'h000C_0000;
  localparam logic [31:0] HI_MEM_BASE = 32'h00F0_0000;
  localparam logic [31:0] HI_MEM_TOP = 32'h0100_0000;
  localparam logic [31:0] KB128 = 32'h0002_0000;
  localparam logic [31:0] KB256 = 32'h0004_0000;
  localparam logic [31:0] KB384 = 32'h0006_0000;
  localparam logic [31:0] MB1 = 32'h0010_0000;
  localparam logic [31:0] KB64 = 32'h0001_0000;
  localparam logic [31:0] KB32 = 32'h0000_8000;
  localparam int DEVSEL_WAIT = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T2A = 3'b001,
    ST_T2B = 3'b011,
    ST_PROBE = 3'b010,
    ST_PCI = 3'b110,
    ST_ISA = 3'b111,
    ST_DONE = 3'b101
  } vlsd_state_type;

  typedef enum logic [2:0] {
    PATH_NONE = 3'h0,
    PATH_MEM = 3'h1,
    PATH_VL = 3'h2,
    PATH_OWN = 3'h3,
    PATH_PCI = 3'h4,
    PATH_ISA = 3'h5
  } vlsd_path_type;

  typedef struct packed {
    logic start;
    logic [31:0] addr;
    logic write;
    logic mem;
    logic cfg;
  } vlsd_cycle_type;

  typedef struct packed {
    logic wr;
    logic [7:0] index;
    logic [7:0] data;
  } vlsd_regwr_type;
endpackage : vlsd_pkg

// ---- verilog/vlsd_mem_decode.sv ----
// vlsd_mem_decode: combinational on-board memory hit from the mirrored
// chipset registers; assumes registers are stable during a cycle.
`timescale 1ns/1ps
module vlsd_mem_decode (
  input wire logic [31:0] addr_in,
  input wire logic write_in,
  input wire logic [7:0] dram_size_in,
  input wire logic [7:0] shadow_a_in,
  input wire logic [7:0] shadow_b_in,
  input wire logic [7:0] shadow_c_in,
  input wire logic [7:0] reloc_in,
  input wire logic [7:0] smm_in,
  output logic hit_out
);
  import vlsd_pkg::*;
  logic [31:0] top;
  logic [31:0] reloc_len;
  logic [3:0] blk;
  logic [7:0] shbits;
  logic shadow_hit;
  always_comb
  begin
    top = {4'h0, dram_size_in, 20'h0_0000};
    reloc_len = 32'h0;
    if (reloc_in[RELOC_384_BIT])
      reloc_len = smm_in[SMM_ON_BIT] ? KB256 : KB384;
    else if (reloc_in[RELOC_256_BIT])
      reloc_len = smm_in[SMM_ON_BIT] ? KB128 : KB256;
    blk = addr_in[17:14];
    // each register covers 64KB, read bits even, write bits odd
    shbits = (blk[3:2] == 2'd0) ? shadow_a_in :
             (blk[3:2] == 2'd1) ? shadow_b_in : shadow_c_in;
    shadow_hit = 1'b0;
    if (addr_in >= SHADOW_BASE && addr_in < MB1 && blk[3:2] != 2'd3)
      shadow_hit = shbits[{blk[1:0], write_in}];
    hit_out = 1'b0;
    if (addr_in < SMM_BASE)
      hit_out = 1'b1;
    else if (addr_in < SMM_TOP)
      hit_out = smm_in[SMM_AB_BIT];
    else if (addr_in < MB1)
      hit_out = shadow_hit;
    else if (addr_in >= HI_MEM_BASE && addr_in < HI_MEM_TOP)
      hit_out = shadow_c_in[SHC_HI_MEM_BIT];
    else if (addr_in < top)
      hit_out = 1'b1;
    else if (addr_in < top + reloc_len)
      hit_out = 1'b1;
  end
endmodule : vlsd_mem_decode

// ---- verilog/vlsd_decoder.sv ----
// vlsd_decoder: vl slave cycle decoder choosing memory, vl, own register,
// pci or isa path; assumes cycle start pulses with T1 and t2_in per T2.
`timescale 1ns/1ps
// Operation
// - On-board memory cycles: stay idle, chipset returns ready.
// - Cycles to another vl device: do not respond, wait its ready.
// - Own register or config cycles: bridge drives ready at cycle end.
// - Dram size register gives address bits 20-27 of dram top.
// - Shadow bits per 16KB in C0000-EFFFF, read and write separate.
// - Third shadow register bit 2 maps 15-16MB to dram.
// - Relocation bits 2,3 add 256K or 384K above dram.
// - Smm bit 3 shrinks relocation to 128K or 256K.
// - Smm bit 4 maps A0000-BFFFF to dram.
// - Mirror registers capture the same io write as the chipset.
// - Sample foreign ldev at end of first or second T2 per bit 6.
// - Own register or config cycles claimed by end of first T2.
// - Accelerated pci window hits claimed by end of first T2.
// - Buffered window writes get ready by end of second T2; the code does so only while wbuf_room_in is set, else it starts a pci frame.
// - Then check fast isa window, A0000-D7FFF in 32K steps or A0000-FFFFF in 64K steps.
// - Fast isa hit drives ldev after second T2.
// - Else start pci frame; devsel makes it pci, ldev stays off.
// - Trdy passes straight through or resynchronised per bit 5.
// - No devsel in time: treat as isa and drive ldev.
// - Window attributes: pci and buffer enables and 64KB-8MB size.
module vlsd_decoder #(
  parameter int DEVSEL_CYCLES = vlsd_pkg::DEVSEL_WAIT
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire vlsd_pkg::vlsd_cycle_type cyc_in,
  input wire logic t2_in,
  input wire logic cycle_end_in,
  input wire logic own_reg_hit_in,
  input wire vlsd_pkg::vlsd_regwr_type regwr_in,
  input wire logic ldev_foreign_n_in,
  input wire logic wbuf_room_in,
  input wire logic devsel_n_in,
  input wire logic trdy_n_in,
  output logic ldev_n_out,
  output logic lrdy_n_out,
  output logic frame_req_out,
  output vlsd_pkg::vlsd_path_type path_out,
  output logic [7:0] bus_timing_out
);
  import vlsd_pkg::*;

  function automatic logic [31:0] win_mask(input logic [2:0] sz);
    win_mask = ~((KB64 << sz) - 32'h1);
  endfunction : win_mask

  function automatic logic [7:0] reg_pick(input vlsd_regwr_type w,
                                          input logic [7:0] idx,
                                          input logic [7:0] cur);
    reg_pick = (w.wr && w.index == idx) ? w.data : cur;
  endfunction : reg_pick

  logic [7:0] shadow_a_r, shadow_b_r, shadow_c_r, reloc_r, smm_r;
  logic [7:0] dram_size_r, bus_timing_r, fast_isa_r;
  logic [7:0] win_hi_r [NUM_WIN];
  logic [7:0] win_mid_r [NUM_WIN];
  logic [7:0] win_attr_r [NUM_WIN];
  logic [NUM_WIN-1:0] win_prog_r;
  vlsd_state_type state_r;
  vlsd_path_type path_r;
  logic [31:0] addr_r;
  logic write_r, mem_r, cfg_r, own_r;
  logic ldev_r, lrdy_r, frame_r, trdy_sync_r;
  logic [7:0] wait_r;
  logic mem_hit, win_hit, win_wbuf, isa_hit;
  logic [31:0] isa_step;

  // mirrors latch the same io write that programs the chipset
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      shadow_a_r <= 8'h00;
      shadow_b_r <= 8'h00;
      shadow_c_r <= 8'h00;
      reloc_r <= 8'h00;
      smm_r <= 8'h00;
      dram_size_r <= 8'h00;
      bus_timing_r <= 8'h00;
      fast_isa_r <= 8'h00;
    end
    else if (clk_en_in)
    begin
      shadow_a_r <= reg_pick(regwr_in, REG_SHADOW_A, shadow_a_r);
      shadow_b_r <= reg_pick(regwr_in, REG_SHADOW_B, shadow_b_r);
      shadow_c_r <= reg_pick(regwr_in, REG_SHADOW_C, shadow_c_r);
      reloc_r <= reg_pick(regwr_in, REG_RELOC, reloc_r);
      smm_r <= reg_pick(regwr_in, REG_SMM, smm_r);
      dram_size_r <= reg_pick(regwr_in, REG_DRAM_SIZE, dram_size_r);
      bus_timing_r <= reg_pick(regwr_in, REG_BUS_TIMING, bus_timing_r);
      fast_isa_r <= reg_pick(regwr_in, REG_FAST_ISA, fast_isa_r);
    end
  end

  // window registers; a window counts only once its attribute is written
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NUM_WIN; i++)
      begin
        win_hi_r[i] <= 8'h00;
        win_mid_r[i] <= 8'h00;
        win_attr_r[i] <= 8'h00;
      end
      win_prog_r <= '0;
    end
    else if (clk_en_in)
    begin
      for (int i = 0; i < NUM_WIN; i++)
      begin
        win_hi_r[i] <= reg_pick(regwr_in, 8'(REG_WIN_START + REG_WIN_STEP * i),
                                win_hi_r[i]);
        win_mid_r[i] <= reg_pick(regwr_in,
                                 8'(REG_WIN_START + REG_WIN_STEP * i + 1),
                                 win_mid_r[i]);
        win_attr_r[i] <= reg_pick(regwr_in,
                                  8'(REG_WIN_START + REG_WIN_STEP * i + 2),
                                  win_attr_r[i]);
        if (regwr_in.wr && regwr_in.index == 8'(REG_WIN_START + REG_WIN_STEP * i + 2))
          win_prog_r[i] <= 1'b1;
      end
    end
  end

  vlsd_mem_decode u_mem (
    .addr_in(addr_r),
    .write_in(write_r),
    .dram_size_in(dram_size_r),
    .shadow_a_in(shadow_a_r),
    .shadow_b_in(shadow_b_r),
    .shadow_c_in(shadow_c_r),
    .reloc_in(reloc_r),
    .smm_in(smm_r),
    .hit_out(mem_hit)
  );

  always_comb
  begin
    win_hit = 1'b0;
    win_wbuf = 1'b0;
    for (int i = 0; i < NUM_WIN; i++)
    begin
      if (mem_r && win_prog_r[i] && win_attr_r[i][WA_PCI_EN_BIT] &&
          ((addr_r ^ {win_hi_r[i], win_mid_r[i], 16'h0000}) &
           win_mask(win_attr_r[i][WA_SIZE_LSB +: 3])) == 32'h0)
      begin
        win_hit = 1'b1;
        win_wbuf = win_wbuf | win_attr_r[i][WA_WBUF_EN_BIT];
      end
    end
    // fast isa: low 7 bits mark steps from A0000, bit 7 picks 64K steps
    isa_step = fast_isa_r[FI_SIZE64_BIT] ? KB64 : KB32;
    isa_hit = 1'b0;
    for (int j = 0; j < 7; j++)
      if (mem_r && fast_isa_r[j] && addr_r >= SMM_BASE + isa_step * j &&
          addr_r < SMM_BASE + isa_step * (j + 1) && addr_r < MB1)
        isa_hit = 1'b1;
  end

  // cycle sequencer
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      path_r <= PATH_NONE;
      addr_r <= 32'h0;
      write_r <= 1'b0;
      mem_r <= 1'b0;
      cfg_r <= 1'b0;
      own_r <= 1'b0;
      ldev_r <= 1'b0;
      lrdy_r <= 1'b0;
      frame_r <= 1'b0;
      wait_r <= 8'h00;
    end
    else if (clk_en_in)
    begin
      lrdy_r <= 1'b0;
      frame_r <= 1'b0;
      unique case (state_r)
        ST_IDLE:
          if (cyc_in.start)
          begin
            addr_r <= cyc_in.addr;
            write_r <= cyc_in.write;
            mem_r <= cyc_in.mem;
            cfg_r <= cyc_in.cfg;
            own_r <= own_reg_hit_in;
            path_r <= PATH_NONE;
            ldev_r <= 1'b0;
            state_r <= ST_T2A;
          end
        ST_T2A:
          if (t2_in)
          begin
            if (own_r || cfg_r)
            begin
              path_r <= PATH_OWN;
              ldev_r <= 1'b1;
              state_r <= ST_PCI;
            end
            else if (mem_r && mem_hit)
            begin
              path_r <= PATH_MEM;
              state_r <= ST_DONE;
            end
            else if (win_hit)
            begin
              path_r <= PATH_PCI;
              ldev_r <= 1'b1;
              state_r <= ST_T2B;
            end
            else if (!bus_timing_r[BT_LATE_SAMPLE_BIT] && !ldev_foreign_n_in)
            begin
              path_r <= PATH_VL;
              state_r <= ST_DONE;
            end
            else
              state_r <= ST_T2B;
          end
        ST_T2B:
          if (t2_in)
          begin
            if (path_r == PATH_PCI)
            begin
              if (write_r && win_wbuf && wbuf_room_in)
              begin
                lrdy_r <= 1'b1;
                state_r <= ST_DONE;
              end
              else
              begin
                frame_r <= 1'b1;
                state_r <= ST_PCI;
              end
            end
            else if (bus_timing_r[BT_LATE_SAMPLE_BIT] && !ldev_foreign_n_in)
            begin
              path_r <= PATH_VL;
              state_r <= ST_DONE;
            end
            else if (isa_hit)
            begin
              path_r <= PATH_ISA;
              ldev_r <= 1'b1;
              state_r <= ST_DONE;
            end
            else
            begin
              frame_r <= 1'b1;
              wait_r <= 8'h00;
              state_r <= ST_PROBE;
            end
          end
        ST_PROBE:
        begin
          if (!devsel_n_in)
          begin
            path_r <= PATH_PCI;
            state_r <= ST_PCI;
          end
          else if (wait_r == 8'(DEVSEL_CYCLES - 1))
          begin
            path_r <= PATH_ISA;
            ldev_r <= 1'b1;
            state_r <= ST_DONE;
          end
          else
            wait_r <= wait_r + 8'h01;
        end
        ST_PCI:
          if (own_r || cfg_r ? cycle_end_in :
              (bus_timing_r[BT_TRDY_SYNC_BIT] ? trdy_sync_r : !trdy_n_in))
          begin
            lrdy_r <= 1'b1;
            state_r <= ST_DONE;
          end
        ST_DONE:
          if (cycle_end_in || own_r || cfg_r)
          begin
            ldev_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // resynchronised target ready
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      trdy_sync_r <= 1'b0;
    else if (clk_en_in)
      trdy_sync_r <= !trdy_n_in && state_r == ST_PCI && !trdy_sync_r;
  end

  assign ldev_n_out = !ldev_r;
  assign lrdy_n_out = !lrdy_r;
  assign frame_req_out = frame_r;
  assign path_out = path_r;
  assign bus_timing_out = bus_timing_r;

  property p_mem_idle;
    @(posedge sys_clk_in) disable iff (rst_in)
      path_r == PATH_MEM |-> ldev_n_out && lrdy_n_out;
  endproperty
  a_mem_idle: assert property (p_mem_idle) else $error("memory path drove vl");

  property p_vl_quiet;
    @(posedge sys_clk_in) disable iff (rst_in)
      path_r == PATH_VL |-> ldev_n_out && lrdy_n_out;
  endproperty
  a_vl_quiet: assert property (p_vl_quiet) else $error("vl path responded");

  property p_early_claim;
    @(posedge sys_clk_in) disable iff (rst_in)
      state_r == ST_T2A && t2_in && clk_en_in && (own_r || cfg_r) |=> !ldev_n_out;
  endproperty
  a_early_claim: assert property (p_early_claim) else $error("own claim late");

  property p_win_claim;
    @(posedge sys_clk_in) disable iff (rst_in)
      state_r == ST_T2A && t2_in && clk_en_in && !own_r && !cfg_r && !(mem_r && mem_hit)
      && win_hit |=> !ldev_n_out && path_r == PATH_PCI;
  endproperty
  a_win_claim: assert property (p_win_claim) else $error("window claim missed");

  property p_unprog;
    @(posedge sys_clk_in) disable iff (rst_in)
      state_r == ST_T2A && t2_in && clk_en_in && win_prog_r == '0 && !own_r && !cfg_r |=> ldev_n_out;
  endproperty
  a_unprog: assert property (p_unprog) else $error("unprogrammed window hit");

  sequence s_probe_start;
    state_r == ST_PROBE && wait_r == 8'h00 && frame_r;
  endsequence

  property p_no_devsel;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_probe_start ##0 (devsel_n_in && clk_en_in) [*5] |=> !ldev_n_out && path_r == PATH_ISA;
  endproperty
  a_no_devsel: assert property (p_no_devsel) else $error("isa fallback missed");

  property p_devsel_quiet;
    @(posedge sys_clk_in) disable iff (rst_in)
      state_r == ST_PROBE && !devsel_n_in && clk_en_in |=> ldev_n_out;
  endproperty
  a_devsel_quiet: assert property (p_devsel_quiet) else $error("ldev on pci");

  property p_pass_trdy;
    @(posedge sys_clk_in) disable iff (rst_in)
      state_r == ST_PCI && !own_r && !cfg_r && clk_en_in && !trdy_n_in
      && !bus_timing_r[BT_TRDY_SYNC_BIT] |=> !lrdy_n_out;
  endproperty
  a_pass_trdy: assert property (p_pass_trdy) else $error("trdy not passed");
endmodule : vlsd_decoder

// ---- testbench/vlsd_pci_target.sv ----
// vlsd_pci_target: behavioural pci target that answers frame requests
// assumes frame_req_in is a one-cycle pulse; released lines float high
`timescale 1ns/1ps
module vlsd_pci_target (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic frame_req_in,
  input wire logic respond_in,
  input wire logic [3:0] delay_in,
  output logic devsel_n_out = 1'h1,
  output logic trdy_n_out = 1'h1
);
  logic busy_r = 1'h0;
  logic [3:0] cnt_r = 4'h0;

  // devsel after delay_in cycles, trdy for one cycle after it, then release
  always @(posedge sys_clk_in)
  begin
    devsel_n_out <= 1'h1;
    trdy_n_out <= 1'h1;
    if (rst_in)
    begin
      busy_r <= 1'h0;
    end
    else if (frame_req_in && respond_in)
    begin
      busy_r <= 1'h1;
      cnt_r <= delay_in;
    end
    else if (busy_r)
    begin
      devsel_n_out <= (cnt_r > 4'h1);
      trdy_n_out <= (cnt_r != 4'h0);
      busy_r <= (cnt_r != 4'h0);
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : vlsd_pci_target

// ---- testbench/vlsd_decoder_test.sv ----
// vlsd_decoder_test: table of decode cases plus reset and corner cases
// assumes the decoder and the pci target model are compiled before it
`timescale 1ns/1ps
`define VLSD_CHECK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module vlsd_decoder_test;
  import vlsd_pkg::*;
  typedef struct packed {
    logic [31:0] addr;
    logic [4:0] kind;
    logic [1:0] fgn;
    logic [1:0] resp;
    logic [2:0] path;
    logic [1:0] ldev;
    logic lrdy;
    logic frame;
  } vlsd_row_type;
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic clk_en_in = 1'h1;
  vlsd_cycle_type cyc_in = '0;
  logic t2_in = 1'h0;
  logic cycle_end_in = 1'h0;
  logic own_reg_hit_in = 1'h0;
  vlsd_regwr_type regwr_in = '0;
  logic ldev_foreign_n_in = 1'h1;
  logic wbuf_room_in = 1'h1;
  logic resp = 1'h0;
  logic [3:0] dly = 4'h1;
  logic devsel_n;
  logic trdy_n;
  logic ldev_n;
  logic lrdy_n;
  logic frame_req;
  vlsd_path_type path;
  logic [7:0] bus_timing;
  int fail_count = 0;
  int tests_run = 0;
  logic [15:0] cfg_tab [13] = '{16'h8104, 16'h3001, 16'h3204, 16'h3304, 16'h5B10,
    16'h8300, 16'h8780, 16'h8800, 16'h89C0, 16'h8A90, 16'h8B00, 16'h8C9C, 16'h9288};
  vlsd_row_type rows [18];

  always #5 sys_clk_in = ~sys_clk_in;

  vlsd_decoder #(.DEVSEL_CYCLES(5)) vlsd_decoder_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .cyc_in(cyc_in),
    .t2_in(t2_in), .cycle_end_in(cycle_end_in), .own_reg_hit_in(own_reg_hit_in),
    .regwr_in(regwr_in), .ldev_foreign_n_in(ldev_foreign_n_in),
    .wbuf_room_in(wbuf_room_in), .devsel_n_in(devsel_n), .trdy_n_in(trdy_n),
    .ldev_n_out(ldev_n), .lrdy_n_out(lrdy_n), .frame_req_out(frame_req),
    .path_out(path), .bus_timing_out(bus_timing));

  vlsd_pci_target vlsd_pci_target_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .frame_req_in(frame_req),
    .respond_in(resp), .delay_in(dly), .devsel_n_out(devsel_n), .trdy_n_out(trdy_n));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // one-cycle io write, seen by both the chipset and the mirror registers
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    regwr_in = '{1'h1, idx, val};
    @(negedge sys_clk_in);
    regwr_in = '0;
    @(negedge sys_clk_in);
  endtask : reg_wr

  // start, two T2 pulses, then the chipset or device ends the cycle
  task automatic run_cycle(input vlsd_row_type r);
    int ldev_at = 0;
    int ended = 0;
    logic saw_lrdy = 1'h0;
    logic saw_frame = 1'h0;
    logic [2:0] p = 3'h0;
    logic [1:0] cls;
    resp = (r.resp != 2'h0);
    dly = (r.resp == 2'h2) ? 4'h3 : 4'h1;
    {cyc_in.write, cyc_in.mem, cyc_in.cfg, own_reg_hit_in, wbuf_room_in} = r.kind;
    cyc_in.addr = r.addr;
    cyc_in.start = 1'h1;
    for (int s = 1; ended < 4; s++)
    begin
      @(negedge sys_clk_in);
      if (ldev_n === 1'h0 && ldev_at == 0)
        ldev_at = s;
      saw_lrdy |= (lrdy_n === 1'h0);
      saw_frame |= (frame_req === 1'h1);
      if (s == 1)
        cyc_in.start = 1'h0;
      t2_in = (s <= 2);
      cycle_end_in = 1'h0;
      ldev_foreign_n_in = ended > 0 || !(r.fgn == 2'h1 || (r.fgn == 2'h2 && s >= 2));
      if (ended > 0)
        ended++;
      else if (s >= 4 && (saw_lrdy || path inside {PATH_MEM, PATH_VL, PATH_ISA, PATH_OWN}))
      begin
        p = path;
        cycle_end_in = 1'h1;
        ended = 1;
      end
      else if (s >= 40)
      begin
        fail_count++;
        stop_test();
      end
    end
    cls = (ldev_at == 0) ? 2'h0 : (ldev_at <= 2) ? 2'h1 : (ldev_at == 3) ? 2'h2 : 2'h3;
    `VLSD_CHECK(cls, r.ldev);
    `VLSD_CHECK(saw_lrdy, r.lrdy);
    if (r.path != 3'h7)
    begin
      `VLSD_CHECK(p, r.path);
      `VLSD_CHECK(saw_frame, r.frame);
    end
    `VLSD_CHECK(ldev_n, 1'h1);
  endtask : run_cycle

  initial
  begin
    rows = '{
      '{32'h0010_0000, 5'h08, 2'h0, 2'h0, 3'h1, 2'h0, 1'h0, 1'h0},  // dram
      '{32'h003F_FFFC, 5'h08, 2'h0, 2'h0, 3'h1, 2'h0, 1'h0, 1'h0},  // last dram word
      '{32'h0044_0000, 5'h08, 2'h0, 2'h0, 3'h5, 2'h3, 1'h0, 1'h1},  // past relocation
      '{32'h0043_FFF0, 5'h08, 2'h0, 2'h0, 3'h1, 2'h0, 1'h0, 1'h0},  // relocated 256K
      '{32'h000C_0000, 5'h08, 2'h0, 2'h0, 3'h1, 2'h0, 1'h0, 1'h0},  // shadow read
      '{32'h000C_0000, 5'h18, 2'h0, 2'h1, 3'h4, 2'h0, 1'h1, 1'h1},  // shadow write off
      '{32'h00F8_0000, 5'h08, 2'h0, 2'h0, 3'h1, 2'h0, 1'h0, 1'h0},  // 15-16MB hole
      '{32'h000A_0000, 5'h08, 2'h0, 2'h0, 3'h1, 2'h0, 1'h0, 1'h0},  // sys mgmt area
      '{32'h8000_0000, 5'h19, 2'h0, 2'h0, 3'h4, 2'h1, 1'h1, 1'h0},  // buffered write
      '{32'h8000_FFF0, 5'h18, 2'h0, 2'h1, 3'h4, 2'h1, 1'h1, 1'h1},  // buffer full
      '{32'h907F_FFF0, 5'h09, 2'h0, 2'h1, 3'h4, 2'h1, 1'h1, 1'h1},  // 8MB window top
      '{32'h9080_0000, 5'h09, 2'h0, 2'h2, 3'h4, 2'h0, 1'h1, 1'h1},  // slow devsel
      '{32'h0000_0CFC, 5'h03, 2'h0, 2'h0, 3'h3, 2'h1, 1'h1, 1'h0},  // own register
      '{32'h8000_0CFC, 5'h05, 2'h0, 2'h1, 3'h7, 2'h1, 1'h1, 1'h0},  // config cycle
      '{32'h000D_0000, 5'h09, 2'h0, 2'h0, 3'h5, 2'h2, 1'h0, 1'h0},  // fast isa 64K
      '{32'h000E_0000, 5'h09, 2'h0, 2'h0, 3'h5, 2'h3, 1'h0, 1'h1},  // no devsel
      '{32'h0200_0000, 5'h09, 2'h1, 2'h0, 3'h2, 2'h0, 1'h0, 1'h0},  // vl device
      '{32'h0200_0000, 5'h09, 2'h2, 2'h0, 3'h5, 2'h3, 1'h0, 1'h1}}; // late vl claim
    repeat (3) @(negedge sys_clk_in);
    rst_in = 1'h0;
    foreach (cfg_tab[i])
      reg_wr(cfg_tab[i][15:8], cfg_tab[i][7:0]);
    foreach (rows[i])
      run_cycle(rows[i]);
    reg_wr(REG_SMM, 8'h18);
    run_cycle('{32'h0043_FFF0, 5'h08, 2'h0, 2'h0, 3'h5, 2'h3, 1'h0, 1'h1});
    run_cycle('{32'h0041_FFF0, 5'h08, 2'h0, 2'h0, 3'h1, 2'h0, 1'h0, 1'h0});
    reg_wr(REG_BUS_TIMING, 8'h60);
    `VLSD_CHECK(bus_timing, 8'h60);
    run_cycle('{32'h0200_0000, 5'h09, 2'h2, 2'h0, 3'h2, 2'h0, 1'h0, 1'h0});
    run_cycle(rows[11]);
    rst_in = 1'h1;
    @(negedge sys_clk_in);
    rst_in = 1'h0;
    `VLSD_CHECK({ldev_n, lrdy_n, frame_req, path}, 6'h30);
    `VLSD_CHECK(bus_timing, 8'h00);
    run_cycle('{32'h8000_0000, 5'h19, 2'h0, 2'h0, 3'h5, 2'h3, 1'h0, 1'h1});
    stop_test();
  end
endmodule : vlsd_decoder_test
